// [pin_change_pkg.sv]
// constants shared by the port E/F pin-change interrupt block
`default_nettype none

package pin_change_pkg;

	// ==========================================================
	// register addresses
	localparam logic [7:0] PORT_E_MASK_ADDR = 8'h73;
	localparam logic [7:0] PORT_F_MASK_ADDR = 8'h74;
	localparam logic [7:0] FLAG_ADDR = 8'h75;
	localparam logic [7:0] GROUP_EN_ADDR = 8'h76;
	localparam logic [7:0] LEVEL_E_ADDR = 8'h77;
	localparam logic [7:0] LEVEL_F_ADDR = 8'h78;

	// ==========================================================
	// field positions (flag and group enable share one layout)
	localparam int unsigned PORT_E_BIT = 0;
	localparam int unsigned PORT_F_BIT = 1;

	// ==========================================================
	// reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [1:0] FLAG_RESET = 2'h0;
	localparam logic [1:0] GROUP_EN_RESET = 2'h0;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// ==========================================================
	// timing: edges after reset release before change outputs are trusted
	localparam logic [1:0] PRIME_RESET = 2'h0;
	localparam logic [1:0] PRIME_DONE = 2'h3;
	localparam logic [1:0] PRIME_STEP = 2'h1;

endpackage

`default_nettype wire

// [pin_change_detect.sv]
// per-pin synchroniser and level-change detector for one 8-pin port
`timescale 1ns/10ps
`default_nettype none

module pin_change_detect (
	input wire logic clk, // system clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic [7:0] pins, // raw port pins
	output logic [7:0] level, // synchronised pin levels
	output logic [7:0] change // one-cycle pulse per pin that changed
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] meta;
		logic [7:0] sync;
		logic [7:0] prev;
		logic [7:0] chg;
		logic [1:0] prime;
	} det_t;

	det_t s_q;
	det_t s_d;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.meta = pins;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		// both edges count; history is not trusted right after reset
		if (s_q.prime == pin_change_pkg::PRIME_DONE) begin
			s_d.chg = s_q.sync ^ s_q.prev;
		end else begin
			s_d.chg = 8'h00;
			s_d.prime = s_q.prime + pin_change_pkg::PRIME_STEP;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q.meta <= 8'h00;
			s_q.sync <= 8'h00;
			s_q.prev <= 8'h00;
			s_q.chg <= 8'h00;
			s_q.prime <= pin_change_pkg::PRIME_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.sync;
	assign change = s_q.chg;

	// ==========================================================
	// checks
	AST_CHANGE_BOTH_EDGES: assert property (
		($past(s_q.prime) == pin_change_pkg::PRIME_DONE)
		|-> (change == ($past(pins, 3) ^ $past(pins, 4))))
		else $error("pin change not seen three cycles after the pin moved");

	AST_NO_CHANGE_UNPRIMED: assert property (
		(s_q.prime != pin_change_pkg::PRIME_DONE) |=> (change == 8'h00))
		else $error("change reported before synchroniser history was valid");

endmodule // pin_change_detect

`default_nettype wire

// [pin_change_irq_ports_e_f.sv]
// pin-change mask, flag and interrupt logic for ports E and F
//
// Contract
// - port E mask at 0x73, reset zero
// - port F mask at 0x74, reset zero
// - enabled port E pin change sets flag
// - port E irq needs flag, group, global
// - enabled port F pin change sets flag
// - port F irq needs flag, group, global
// - masked pins never affect flag or irq
`timescale 1ns/10ps
`default_nettype none

module pin_change_irq_ports_e_f (
	input wire logic clk, // system clock, 25 MHz
	input wire logic nrst, // asynchronous reset, active low
	input wire logic [7:0] addr, // register address
	input wire logic [7:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [7:0] rdata, // read data, cycle after rd
	input wire logic [7:0] port_e_pins, // port E pins
	input wire logic [7:0] port_f_pins, // port F pins
	input wire logic global_irq_enable, // CPU global interrupt enable
	output logic port_e_change_irq, // port E interrupt request
	output logic port_f_change_irq, // port F interrupt request
	output logic irq // any flag set whose group enable is set
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] port_e_change_mask;
		logic [7:0] port_f_change_mask;
		logic [1:0] change_flag;
		logic [1:0] group_enable;
		logic [7:0] rdata;
	} ctl_t;

	ctl_t c_q;
	ctl_t c_d;

	logic [7:0] level_e;
	logic [7:0] level_f;
	logic [7:0] change_e;
	logic [7:0] change_f;
	logic wr_mask_e;
	logic wr_mask_f;
	logic wr_flag;
	logic wr_group;
	logic [1:0] clear;
	logic set_e;
	logic set_f;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// ==========================================================
	// decode helpers
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	function automatic logic [7:0] read_mux(
		input logic [7:0] a,
		input ctl_t c,
		input logic [7:0] lvl_e,
		input logic [7:0] lvl_f
	);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			pin_change_pkg::PORT_E_MASK_ADDR: v = c.port_e_change_mask;
			pin_change_pkg::PORT_F_MASK_ADDR: v = c.port_f_change_mask;
			pin_change_pkg::FLAG_ADDR: v = {6'h00, c.change_flag};
			pin_change_pkg::GROUP_EN_ADDR: v = {6'h00, c.group_enable};
			pin_change_pkg::LEVEL_E_ADDR: v = lvl_e;
			pin_change_pkg::LEVEL_F_ADDR: v = lvl_f;
			default: v = 8'h00;
		endcase
		read_mux = v;
	endfunction

	// ==========================================================
	// pin watchers
	pin_change_detect det_e (
		.clk(clk),
		.nrst(nrst),
		.pins(port_e_pins),
		.level(level_e),
		.change(change_e)
	);

	pin_change_detect det_f (
		.clk(clk),
		.nrst(nrst),
		.pins(port_f_pins),
		.level(level_f),
		.change(change_f)
	);

	// ==========================================================
	// register writes and flag events
	assign wr_mask_e = wr && addr_hit(addr, pin_change_pkg::PORT_E_MASK_ADDR);
	assign wr_mask_f = wr && addr_hit(addr, pin_change_pkg::PORT_F_MASK_ADDR);
	assign wr_flag = wr && addr_hit(addr, pin_change_pkg::FLAG_ADDR);
	assign wr_group = wr && addr_hit(addr, pin_change_pkg::GROUP_EN_ADDR);
	assign clear = wr_flag ? wdata[1:0] : 2'h0;

	// a masked pin is dropped here, before it can reach a flag
	assign set_e = |(change_e & c_q.port_e_change_mask);
	assign set_f = |(change_f & c_q.port_f_change_mask);

	always_comb begin
		c_d = c_q;
		if (wr_mask_e) begin
			c_d.port_e_change_mask = wdata;
		end
		if (wr_mask_f) begin
			c_d.port_f_change_mask = wdata;
		end
		if (wr_group) begin
			c_d.group_enable = wdata[1:0];
		end
		// set beats a simultaneous write-one-to-clear so no event is lost
		c_d.change_flag[pin_change_pkg::PORT_E_BIT] =
			(c_q.change_flag[pin_change_pkg::PORT_E_BIT]
			& ~clear[pin_change_pkg::PORT_E_BIT]) | set_e;
		c_d.change_flag[pin_change_pkg::PORT_F_BIT] =
			(c_q.change_flag[pin_change_pkg::PORT_F_BIT]
			& ~clear[pin_change_pkg::PORT_F_BIT]) | set_f;
		// read data stand for exactly one cycle
		if (rd) begin
			c_d.rdata = read_mux(addr, c_q, level_e, level_f);
		end else begin
			c_d.rdata = pin_change_pkg::RDATA_IDLE;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			c_q.port_e_change_mask <= pin_change_pkg::MASK_RESET;
			c_q.port_f_change_mask <= pin_change_pkg::MASK_RESET;
			c_q.change_flag <= pin_change_pkg::FLAG_RESET;
			c_q.group_enable <= pin_change_pkg::GROUP_EN_RESET;
			c_q.rdata <= pin_change_pkg::RDATA_IDLE;
		end else begin
			c_q <= c_d;
		end
	end

	// ==========================================================
	// outputs
	assign rdata = c_q.rdata;

	assign port_e_change_irq = c_q.change_flag[pin_change_pkg::PORT_E_BIT]
		& c_q.group_enable[pin_change_pkg::PORT_E_BIT]
		& global_irq_enable;
	assign port_f_change_irq = c_q.change_flag[pin_change_pkg::PORT_F_BIT]
		& c_q.group_enable[pin_change_pkg::PORT_F_BIT]
		& global_irq_enable;

	// summary line ignores the global enable; the CPU gates it itself
	assign irq = |(c_q.change_flag & c_q.group_enable);

	// ==========================================================
	// checks: mask registers
	AST_MASK_E_WRITE: assert property (
		wr_mask_e |=> (c_q.port_e_change_mask == $past(wdata)))
		else $error("port E mask did not take the written value");

	AST_MASK_E_HOLD: assert property (
		!wr_mask_e |=> $stable(c_q.port_e_change_mask))
		else $error("port E mask changed without a write");

	AST_READ_MASK_E: assert property (
		(rd && addr_hit(addr, pin_change_pkg::PORT_E_MASK_ADDR))
		|=> (rdata == $past(c_q.port_e_change_mask)))
		else $error("port E mask read returned wrong data");

	AST_MASK_F_WRITE: assert property (
		wr_mask_f |=> (c_q.port_f_change_mask == $past(wdata)))
		else $error("port F mask did not take the written value");

	AST_MASK_F_HOLD: assert property (
		!wr_mask_f |=> $stable(c_q.port_f_change_mask))
		else $error("port F mask changed without a write");

	AST_READ_MASK_F: assert property (
		(rd && addr_hit(addr, pin_change_pkg::PORT_F_MASK_ADDR))
		|=> (rdata == $past(c_q.port_f_change_mask)))
		else $error("port F mask read returned wrong data");

	AST_READ_ONE_CYCLE: assert property (
		!rd |=> (rdata == pin_change_pkg::RDATA_IDLE))
		else $error("read data held beyond the cycle after the strobe");

	// ==========================================================
	// checks: flags
	AST_FLAG_E_SET: assert property (
		|(change_e & c_q.port_e_change_mask)
		|=> c_q.change_flag[pin_change_pkg::PORT_E_BIT])
		else $error("enabled port E change did not set its flag");

	AST_FLAG_E_STICKY: assert property (
		(c_q.change_flag[pin_change_pkg::PORT_E_BIT]
		&& !clear[pin_change_pkg::PORT_E_BIT])
		|=> c_q.change_flag[pin_change_pkg::PORT_E_BIT])
		else $error("port E flag dropped without a clear");

	AST_FLAG_F_SET: assert property (
		|(change_f & c_q.port_f_change_mask)
		|=> c_q.change_flag[pin_change_pkg::PORT_F_BIT])
		else $error("enabled port F change did not set its flag");

	AST_FLAG_F_STICKY: assert property (
		(c_q.change_flag[pin_change_pkg::PORT_F_BIT]
		&& !clear[pin_change_pkg::PORT_F_BIT])
		|=> c_q.change_flag[pin_change_pkg::PORT_F_BIT])
		else $error("port F flag dropped without a clear");

	AST_MASKED_E_QUIET: assert property (
		(!c_q.change_flag[pin_change_pkg::PORT_E_BIT]
		&& !(|(change_e & c_q.port_e_change_mask)))
		|=> !c_q.change_flag[pin_change_pkg::PORT_E_BIT])
		else $error("masked port E pin set the flag");

	AST_MASKED_F_QUIET: assert property (
		(!c_q.change_flag[pin_change_pkg::PORT_F_BIT]
		&& !(|(change_f & c_q.port_f_change_mask)))
		|=> !c_q.change_flag[pin_change_pkg::PORT_F_BIT])
		else $error("masked port F pin set the flag");

	// ==========================================================
	// checks: interrupt requests
	AST_IRQ_E_CAUSE: assert property (
		(set_e && c_q.group_enable[pin_change_pkg::PORT_E_BIT] && !wr_group)
		##1 global_irq_enable |-> port_e_change_irq)
		else $error("port E request missing after an enabled change");

	AST_IRQ_E_GATED: assert property (
		port_e_change_irq |-> (global_irq_enable
		&& c_q.group_enable[pin_change_pkg::PORT_E_BIT]
		&& c_q.change_flag[pin_change_pkg::PORT_E_BIT]))
		else $error("port E request raised without all enables");

	AST_IRQ_F_CAUSE: assert property (
		(set_f && c_q.group_enable[pin_change_pkg::PORT_F_BIT] && !wr_group)
		##1 global_irq_enable |-> port_f_change_irq)
		else $error("port F request missing after an enabled change");

	AST_IRQ_F_GATED: assert property (
		port_f_change_irq |-> (global_irq_enable
		&& c_q.group_enable[pin_change_pkg::PORT_F_BIT]
		&& c_q.change_flag[pin_change_pkg::PORT_F_BIT]))
		else $error("port F request raised without all enables");

	AST_IRQ_SUMMARY: assert property (
		(port_e_change_irq || port_f_change_irq) |-> irq)
		else $error("summary interrupt low while a port request is high");

	// ==========================================================
	// checks: clears and group enables
	AST_FLAG_E_CLEAR: assert property (
		(clear[pin_change_pkg::PORT_E_BIT] && !set_e)
		|=> !c_q.change_flag[pin_change_pkg::PORT_E_BIT])
		else $error("port E flag not cleared by a written one");

	AST_FLAG_F_CLEAR: assert property (
		(clear[pin_change_pkg::PORT_F_BIT] && !set_f)
		|=> !c_q.change_flag[pin_change_pkg::PORT_F_BIT])
		else $error("port F flag not cleared by a written one");

	// a flag may only rise through an enabled pin
	AST_FLAG_E_NEEDS_CAUSE: assert property (
		$rose(c_q.change_flag[pin_change_pkg::PORT_E_BIT]) |-> $past(set_e))
		else $error("port E flag rose without an enabled change");

	AST_FLAG_F_NEEDS_CAUSE: assert property (
		$rose(c_q.change_flag[pin_change_pkg::PORT_F_BIT]) |-> $past(set_f))
		else $error("port F flag rose without an enabled change");

	AST_GROUP_WRITE: assert property (
		wr_group |=> (c_q.group_enable == $past(wdata[1:0])))
		else $error("group enables did not take the written value");

	AST_GROUP_HOLD: assert property (
		!wr_group |=> $stable(c_q.group_enable))
		else $error("group enables changed without a write");

	AST_IRQ_E_FALL: assert property (
		(clear[pin_change_pkg::PORT_E_BIT] && !set_e)
		|=> !port_e_change_irq)
		else $error("port E request stayed up after its flag was cleared");

	AST_IRQ_F_FALL: assert property (
		(clear[pin_change_pkg::PORT_F_BIT] && !set_f)
		|=> !port_f_change_irq)
		else $error("port F request stayed up after its flag was cleared");

	AST_IRQ_E_GROUP_OFF: assert property (
		(wr_group && !wdata[pin_change_pkg::PORT_E_BIT])
		|=> !port_e_change_irq)
		else $error("port E request up with its group disabled");

	AST_IRQ_SUMMARY_FALL: assert property (
		(clear == 2'h3 && !set_e && !set_f)
		|=> !irq)
		else $error("summary interrupt up after both flags were cleared");

	// ==========================================================
	// checks: remaining read paths
	AST_READ_FLAG: assert property (
		(rd && addr_hit(addr, pin_change_pkg::FLAG_ADDR))
		|=> (rdata == {6'h00, $past(c_q.change_flag)}))
		else $error("flag read returned wrong data");

	AST_READ_GROUP: assert property (
		(rd && addr_hit(addr, pin_change_pkg::GROUP_EN_ADDR))
		|=> (rdata == {6'h00, $past(c_q.group_enable)}))
		else $error("group enable read returned wrong data");

	AST_READ_LEVEL_E: assert property (
		(rd && addr_hit(addr, pin_change_pkg::LEVEL_E_ADDR))
		|=> (rdata == $past(level_e)))
		else $error("port E level read returned wrong data");

	AST_READ_LEVEL_F: assert property (
		(rd && addr_hit(addr, pin_change_pkg::LEVEL_F_ADDR))
		|=> (rdata == $past(level_f)))
		else $error("port F level read returned wrong data");

	// holes in the map must not leak a neighbour's value
	AST_READ_UNMAPPED: assert property (
		(rd && !addr_hit(addr, pin_change_pkg::PORT_E_MASK_ADDR)
		&& !addr_hit(addr, pin_change_pkg::PORT_F_MASK_ADDR)
		&& !addr_hit(addr, pin_change_pkg::FLAG_ADDR)
		&& !addr_hit(addr, pin_change_pkg::GROUP_EN_ADDR)
		&& !addr_hit(addr, pin_change_pkg::LEVEL_E_ADDR)
		&& !addr_hit(addr, pin_change_pkg::LEVEL_F_ADDR))
		|=> (rdata == pin_change_pkg::RDATA_IDLE))
		else $error("unmapped read returned data");

endmodule // pin_change_irq_ports_e_f

`default_nettype wire

// [pin_env_model.sv]
// model of the port pins and CPU global enable seen by the block
`timescale 1ns/10ps
`default_nettype none

module pin_env_model (
	input wire logic clk, // system clock
	input wire logic nrst, // reset, active low
	input wire logic [7:0] e_req, // wanted port E levels
	input wire logic [7:0] f_req, // wanted port F levels
	input wire logic gie_req, // wanted global enable
	output logic [7:0] port_e_pins, // driven port E pins
	output logic [7:0] port_f_pins, // driven port F pins
	output logic global_irq_enable // CPU global enable
);
	// ==========================================================
	// drivers
	// levels move just after an edge, as push-pull pins would
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_e_pins <= 8'h00;
			port_f_pins <= 8'h00;
			global_irq_enable <= 1'b0;
		end else begin
			port_e_pins <= e_req;
			port_f_pins <= f_req;
			global_irq_enable <= gie_req;
		end
	end
endmodule // pin_env_model

`default_nettype wire

// [tb.sv]
// self-checking testbench for the port E/F pin-change block
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [7:0] e_req = 8'h00;
	logic [7:0] f_req = 8'h00;
	logic gie_req = 1'b0;
	logic [7:0] e_pins;
	logic [7:0] f_pins;
	logic gie;
	logic e_irq;
	logic f_irq;
	logic any_irq;
	int err_total = 0;
	int checked = 0;

	always #20 clk = ~clk;

	pin_env_model pin_env_model_i (.clk(clk), .nrst(nrst), .e_req(e_req), .f_req(f_req),
		.gie_req(gie_req), .port_e_pins(e_pins), .port_f_pins(f_pins),
		.global_irq_enable(gie));

	pin_change_irq_ports_e_f pin_change_irq_ports_e_f_i (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_e_pins(e_pins),
		.port_f_pins(f_pins), .global_irq_enable(gie), .port_e_change_irq(e_irq),
		.port_f_change_irq(f_irq), .irq(any_irq));

	// ==========================================================
	// compare and bus tasks
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk8(what, exp, rdata);
	endtask

	task automatic irq_chk(input logic e, input logic f, input logic any);
		#1;
		chk1("port_e_change_irq", e, e_irq);
		chk1("port_f_change_irq", f, f_irq);
		chk1("irq", any, any_irq);
	endtask

	task automatic results;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ==========================================================
	// tests
	initial begin
		wait_n(8);
		nrst <= 1'b1;
		wait_n(4);
		rd_chk("e_mask", pin_change_pkg::PORT_E_MASK_ADDR, 8'h00);
		rd_chk("f_mask", pin_change_pkg::PORT_F_MASK_ADDR, 8'h00);
		wr_reg(pin_change_pkg::PORT_E_MASK_ADDR, 8'hA5);
		wr_reg(pin_change_pkg::PORT_F_MASK_ADDR, 8'h5A);
		wr_reg(8'h79, 8'hFF);
		rd_chk("e_mask", pin_change_pkg::PORT_E_MASK_ADDR, 8'hA5);
		rd_chk("f_mask", pin_change_pkg::PORT_F_MASK_ADDR, 8'h5A);
		rd_chk("unmapped", 8'h79, 8'h00);
		wr_reg(pin_change_pkg::PORT_E_MASK_ADDR, 8'h01);
		wr_reg(pin_change_pkg::PORT_F_MASK_ADDR, 8'h80);
		wr_reg(pin_change_pkg::GROUP_EN_ADDR, 8'h03);
		@(posedge clk) gie_req <= 1'b1;
		// every pin but the enabled one moves
		@(posedge clk) begin
			e_req <= 8'hFE;
			f_req <= 8'h7F;
		end
		wait_n(8);
		rd_chk("flags", pin_change_pkg::FLAG_ADDR, 8'h00);
		irq_chk(1'b0, 1'b0, 1'b0);
		@(posedge clk) e_req <= 8'hFF;
		wait_n(8);
		rd_chk("flags", pin_change_pkg::FLAG_ADDR, 8'h01);
		irq_chk(1'b1, 1'b0, 1'b1);
		@(posedge clk) gie_req <= 1'b0;
		wait_n(2);
		irq_chk(1'b0, 1'b0, 1'b1);
		@(posedge clk) gie_req <= 1'b1;
		wr_reg(pin_change_pkg::FLAG_ADDR, 8'h01);
		irq_chk(1'b0, 1'b0, 1'b0);
		// falling edge counts as a change too
		@(posedge clk) e_req <= 8'hFE;
		wait_n(8);
		rd_chk("flags", pin_change_pkg::FLAG_ADDR, 8'h01);
		wr_reg(pin_change_pkg::GROUP_EN_ADDR, 8'h02);
		irq_chk(1'b0, 1'b0, 1'b0);
		@(posedge clk) f_req <= 8'hFF;
		wait_n(8);
		rd_chk("flags", pin_change_pkg::FLAG_ADDR, 8'h03);
		irq_chk(1'b0, 1'b1, 1'b1);
		rd_chk("e_level", pin_change_pkg::LEVEL_E_ADDR, 8'hFE);
		rd_chk("f_level", pin_change_pkg::LEVEL_F_ADDR, 8'hFF);
		rd_chk("group", pin_change_pkg::GROUP_EN_ADDR, 8'h02);
		wr_reg(pin_change_pkg::FLAG_ADDR, 8'h03);
		irq_chk(1'b0, 1'b0, 1'b0);
		rd_chk("flags", pin_change_pkg::FLAG_ADDR, 8'h00);
		results;
	end

	// run takes about 100 cycles; cut a hang well past that
	initial begin
		wait_n(2000);
		err_total++;
		results;
	end
endmodule // tb

`default_nettype wire
